/* File: core/bsli_params.svh */
// offsets, field positions, reset values and timing counts of the indicator block
`ifndef BSLI_PARAMS_SVH
`define BSLI_PARAMS_SVH
`define BSLI_OFS_CTRL      8'h00
`define BSLI_OFS_STATUS    8'h04
`define BSLI_OFS_MASK      8'h08
`define BSLI_OFS_CHAN      8'h0c
`define BSLI_OFS_ONES_LIM  8'h10
`define BSLI_OFS_MIN_LEN   8'h14
`define BSLI_OFS_TOK_LIM   8'h18
`define BSLI_OFS_UND_LIM   8'h1c
`define BSLI_OFS_LEDS      8'h20
`define BSLI_CTRL_CHVIEW   0
`define BSLI_ST_CRC        0
`define BSLI_ST_OVER       1
`define BSLI_ST_ABF        2
`define BSLI_ST_TIME       3
`define BSLI_ST_DATA       4
`define BSLI_ST_UNDER      5
`define BSLI_ST_LOOP       6
`define BSLI_NCAT          7
`define BSLI_RST_CHAN      8'h33
`define BSLI_RST_ONES_LIM  16'h0100
`define BSLI_RST_MIN_LEN   16'h0008
`define BSLI_RST_TOK_LIM   16'h1000
`define BSLI_RST_UND_LIM   16'h0400
`define BSLI_CLK_MHZ       10
`define BSLI_FLASH_HALF_US 250000
`define BSLI_FLASH_CYC     (`BSLI_FLASH_HALF_US * `BSLI_CLK_MHZ)
`endif

/* File: core/bsli_pkg.sv */
// types shared by the indicator block
package bsli_pkg;
    // what the four front indicators are showing
    typedef enum logic [1:0] {
        BSLI_M_OFF,
        BSLI_M_FAULT,
        BSLI_M_CHAN,
        BSLI_M_NORMAL
    } bsli_mode_t;
endpackage

/* File: core/bsli_top.sv */
// board status indicator logic with avalon-mm register slave
`timescale 1ns/1ns
`include "bsli_params.svh"
module bsli_top
    import bsli_pkg::*;
#(
    parameter int FLASH_CYC = `BSLI_FLASH_CYC   // cycles per flash half period
)(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,       // byte address
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        board_wdt_fail,    // hardware watchdog failed
    input  wire logic        driver_started,    // host driver released board
    input  wire logic        os_start_fail,     // firmware did not start
    input  wire logic        driver_wdt_expire, // host driver stopped servicing
    input  wire logic        pci_fault,         // host bus interface fault
    input  wire logic        crc_err,           // frame check failure pulse
    input  wire logic        rx_item_arrive,    // received item ready pulse
    input  wire logic        rx_item_taken,     // item taken into module pulse
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_frame_end,      // last bit of frame pulse
    input  wire logic        token_rx,          // baton handed to station
    input  wire logic        bad_code,          // abnormal line code pulse
    input  wire logic        tx_prep_done,      // send preparation step done
    input  wire logic        fwd_loop_fault,
    input  wire logic        rev_loop_fault,
    input  wire logic        tx_active,
    input  wire logic        rx_active,
    input  wire logic        ext_supply_present,
    output logic             run_led,
    output logic             link_err_led,
    output logic             transmit_activity_indicator,
    output logic             rx_activity_led,
    output logic             external_supply_indicator,
    output logic             abnormal_frame_flag
);
    localparam int NC = `BSLI_NCAT;

    // register file
    logic          chview_reg;                  // channel view open
    logic [NC-1:0] status_reg;                  // sticky error categories
    logic [NC-1:0] mask_reg;                    // interrupt enables
    logic [7:0]    chan_reg;                    // assigned channel number
    logic [15:0]   ones_lim_reg;
    logic [15:0]   min_len_reg;
    logic [15:0]   tok_lim_reg;
    logic [15:0]   und_lim_reg;
    logic          resp_reg;                    // bus answer cycle
    // detection state
    logic          pend_reg;                    // received item not yet taken
    logic [15:0]   ones_reg;
    logic [15:0]   bits_reg;
    logic [15:0]   tok_reg;
    logic [15:0]   und_reg;
    logic [31:0]   flash_cnt_reg;
    logic          flash_reg;                   // flash phase
    logic          run_next;
    logic          err_next;
    logic          tx_lamp_next;
    logic          rd_next;
    bsli_mode_t    mode;

    // bus decode
    wire        req      = avs_read | avs_write;
    wire        acc      = req & resp_reg;      // transfer completes this edge
    wire        wr_acc   = acc & avs_write;
    wire        rd_acc   = acc & avs_read;
    wire        sel_ctrl = avs_address == `BSLI_OFS_CTRL;
    wire        sel_st   = avs_address == `BSLI_OFS_STATUS;
    wire        sel_mask = avs_address == `BSLI_OFS_MASK;
    wire        sel_chan = avs_address == `BSLI_OFS_CHAN;
    wire        sel_ones = avs_address == `BSLI_OFS_ONES_LIM;
    wire        sel_minl = avs_address == `BSLI_OFS_MIN_LEN;
    wire        sel_tok  = avs_address == `BSLI_OFS_TOK_LIM;
    wire        sel_und  = avs_address == `BSLI_OFS_UND_LIM;
    wire        sel_leds = avs_address == `BSLI_OFS_LEDS;
    wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wmerge_lo = avs_writedata & be_mask;
    wire [15:0] wd16 = wmerge_lo[15:0];
    wire [15:0] wm16 = be_mask[15:0];

    // one wait cycle, then the answer
    assign avs_waitrequest = req & ~resp_reg;

    // read data selection
    wire [31:0] rd_mux =
        sel_ctrl ? {31'h0, chview_reg} :
        sel_st   ? {{(32-NC){1'b0}}, status_reg} :
        sel_mask ? {{(32-NC){1'b0}}, mask_reg} :
        sel_chan ? {24'h0, chan_reg} :
        sel_ones ? {16'h0, ones_lim_reg} :
        sel_minl ? {16'h0, min_len_reg} :
        sel_tok  ? {16'h0, tok_lim_reg} :
        sel_und  ? {16'h0, und_lim_reg} :
        sel_leds ? {26'h0, abnormal_frame_flag, external_supply_indicator,
                    rx_activity_led, transmit_activity_indicator,
                    link_err_led, run_led} :
        32'h0;                                  // unmapped reads zero

    // bus answer timing and read data
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            resp_reg     <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            resp_reg <= req & ~resp_reg;
            if (req & ~resp_reg)
                avs_readdata <= rd_mux;
        end
    end

    // control registers, byte-lane writes
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chview_reg   <= 1'b0;
            mask_reg     <= '0;
            chan_reg     <= `BSLI_RST_CHAN;
            ones_lim_reg <= `BSLI_RST_ONES_LIM;
            min_len_reg  <= `BSLI_RST_MIN_LEN;
            tok_lim_reg  <= `BSLI_RST_TOK_LIM;
            und_lim_reg  <= `BSLI_RST_UND_LIM;
        end
        else if (wr_acc)
        begin
            if (sel_ctrl && avs_byteenable[0])
                chview_reg <= avs_writedata[`BSLI_CTRL_CHVIEW];
            if (sel_mask && avs_byteenable[0])
                mask_reg <= avs_writedata[NC-1:0];
            if (sel_chan && avs_byteenable[0])
                chan_reg <= avs_writedata[7:0];
            if (sel_ones)
                ones_lim_reg <= (ones_lim_reg & ~wm16) | wd16;
            if (sel_minl)
                min_len_reg <= (min_len_reg & ~wm16) | wd16;
            if (sel_tok)
                tok_lim_reg <= (tok_lim_reg & ~wm16) | wd16;
            if (sel_und)
                und_lim_reg <= (und_lim_reg & ~wm16) | wd16;
        end
    end

    // receive overrun: new item while previous still pending
    wire ev_over = rx_item_arrive & pend_reg & ~rx_item_taken;

    // frame totals including the bit of this cycle
    wire [15:0] ones_tot = ones_reg + 16'(rx_bit_valid & rx_bit);
    wire [15:0] bits_tot = bits_reg + 16'(rx_bit_valid);
    wire ev_abf = rx_frame_end &
                  ((ones_tot >= ones_lim_reg) | (bits_tot < min_len_reg));

    // token and send-preparation watchdogs run only while the board runs
    wire link_run = driver_started & ~board_wdt_fail;
    wire ev_tok = link_run & ~token_rx & (tok_lim_reg != 16'h0) &
                  (tok_reg == tok_lim_reg);
    wire ev_und = link_run & ~tx_prep_done & (und_lim_reg != 16'h0) &
                  (und_reg == und_lim_reg);
    wire ev_loop = fwd_loop_fault | rev_loop_fault;

    // all category events in status bit order
    wire [NC-1:0] ev_vec = {ev_loop, ev_und, bad_code, ev_tok,
                            ev_abf, ev_over, crc_err};
    wire          st_clr = rd_acc & sel_st;
    // a read clears only the bits the host was shown, so a late event is kept
    wire [NC-1:0] st_keep = st_clr ? (status_reg & ~avs_readdata[NC-1:0]) : status_reg;

    // sticky status: set wins over clear-on-read
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            status_reg <= '0;
        else
            status_reg <= st_keep | ev_vec;
    end

    // interrupt level from unmasked categories
    assign irq = |(status_reg & mask_reg);

    // overrun pending item tracker
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pend_reg <= 1'b0;
        else
            pend_reg <= rx_item_arrive | (pend_reg & ~rx_item_taken);
    end

    // frame bit and one counters, cleared at frame end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ones_reg <= 16'h0;
            bits_reg <= 16'h0;
            abnormal_frame_flag <= 1'b0;
        end
        else
        begin
            ones_reg <= rx_frame_end ? 16'h0 : ones_tot;
            bits_reg <= rx_frame_end ? 16'h0 : bits_tot;
            // flag holds the verdict of the last frame
            if (rx_frame_end)
                abnormal_frame_flag <= ev_abf;
        end
    end

    // baton and preparation interval counters
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tok_reg <= 16'h0;
            und_reg <= 16'h0;
        end
        else
        begin
            // restart on arrival, on expiry, or while link is stopped
            tok_reg <= (token_rx | ev_tok | ~link_run) ? 16'h0 : tok_reg + 16'h1;
            und_reg <= (tx_prep_done | ev_und | ~link_run) ? 16'h0 : und_reg + 16'h1;
        end
    end

    // flash divider: phase toggles every half period
    wire flash_tick = flash_cnt_reg == 32'(FLASH_CYC - 1);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_cnt_reg <= 32'h0;
            flash_reg     <= 1'b0;
        end
        else
        begin
            flash_cnt_reg <= flash_tick ? 32'h0 : flash_cnt_reg + 32'h1;
            if (flash_tick)
                flash_reg <= ~flash_reg;
        end
    end

    // board-specific fault and display mode priority
    wire board_fault = os_start_fail | driver_wdt_expire | pci_fault;
    wire cat_any     = |status_reg;
    always_comb
    begin
        if (board_wdt_fail | ~driver_started)
            mode = BSLI_M_OFF;
        else if (board_fault)
            mode = BSLI_M_FAULT;
        else if (chview_reg)
            mode = BSLI_M_CHAN;
        else
            mode = BSLI_M_NORMAL;
    end

    // indicator next values per mode
    always_comb
    begin
        run_next = 1'b0;
        err_next = 1'b0;
        tx_lamp_next = 1'b0;
        rd_next  = 1'b0;
        case (mode)
            BSLI_M_OFF:
            begin
                // run off; link lamps still report what happens
                err_next = cat_any;
                tx_lamp_next = tx_active;
                rd_next  = rx_active;
            end
            BSLI_M_FAULT:
            begin
                run_next = flash_reg;
                err_next = os_start_fail;
                tx_lamp_next = driver_wdt_expire;
                rd_next  = pci_fault;
            end
            BSLI_M_CHAN:
            begin
                // low four channel bits on the four lamps
                run_next = chan_reg[3];
                err_next = chan_reg[2];
                tx_lamp_next = chan_reg[1];
                rd_next  = chan_reg[0];
            end
            BSLI_M_NORMAL:
            begin
                run_next = 1'b1;
                err_next = cat_any;
                tx_lamp_next = tx_active;
                rd_next  = rx_active;
            end
            default:
            begin
                run_next = 1'b0;
            end
        endcase
    end

    // indicator flip-flops
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_led                     <= 1'b0;
            link_err_led                <= 1'b0;
            transmit_activity_indicator <= 1'b0;
            rx_activity_led             <= 1'b0;
            external_supply_indicator   <= 1'b0;
        end
        else
        begin
            run_led                     <= run_next;
            link_err_led                <= err_next;
            transmit_activity_indicator <= tx_lamp_next;
            rx_activity_led             <= rd_next;
            external_supply_indicator   <= ext_supply_present;
        end
    end

    // checks on the indicator and detection logic
    wire normal_now = mode == BSLI_M_NORMAL;
    wire fault_now  = mode == BSLI_M_FAULT;

    sequence s_read_status;
        rd_acc && sel_st;
    endsequence

    property p_run_off;
        @(posedge mclk) disable iff (!rst_n)
        (board_wdt_fail || !driver_started) |=> !run_led;
    endproperty
    a_run_off: assert property (p_run_off) else $error("run lamp not off");

    property p_crc_lamp;
        @(posedge mclk) disable iff (!rst_n)
        (crc_err && normal_now) ##1 normal_now |=> link_err_led;
    endproperty
    a_crc_lamp: assert property (p_crc_lamp) else $error("crc not shown");

    property p_over;
        @(posedge mclk) disable iff (!rst_n)
        (rx_item_arrive && !rx_item_taken) ##1 (rx_item_arrive && !rx_item_taken)
        |=> status_reg[`BSLI_ST_OVER];
    endproperty
    a_over: assert property (p_over) else $error("overrun missed");

    property p_abf;
        @(posedge mclk) disable iff (!rst_n)
        (rx_frame_end && (ones_tot >= ones_lim_reg)) |=>
        (abnormal_frame_flag && status_reg[`BSLI_ST_ABF]);
    endproperty
    a_abf: assert property (p_abf) else $error("abnormal frame missed");

    property p_tok;
        @(posedge mclk) disable iff (!rst_n)
        (link_run && !token_rx && tok_lim_reg != 16'h0 && tok_reg == tok_lim_reg)
        |=> (status_reg[`BSLI_ST_TIME] && tok_reg == 16'h0);
    endproperty
    a_tok: assert property (p_tok) else $error("token timeout missed");

    property p_data;
        @(posedge mclk) disable iff (!rst_n)
        bad_code |=> status_reg[`BSLI_ST_DATA];
    endproperty
    a_data: assert property (p_data) else $error("bad code missed");

    property p_loop;
        @(posedge mclk) disable iff (!rst_n)
        (fwd_loop_fault || rev_loop_fault) |=> status_reg[`BSLI_ST_LOOP];
    endproperty
    a_loop: assert property (p_loop) else $error("loop fault missed");

    property p_read_keep;
        @(posedge mclk) disable iff (!rst_n)
        s_read_status |-> (avs_readdata[NC-1:0] == $past(status_reg));
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("status read wrong");

    property p_fault_lamps;
        @(posedge mclk) disable iff (!rst_n)
        fault_now |=> (link_err_led == $past(os_start_fail) &&
                       transmit_activity_indicator == $past(driver_wdt_expire) &&
                       rx_activity_led == $past(pci_fault));
    endproperty
    a_fault_lamps: assert property (p_fault_lamps) else $error("fault lamps wrong");

    property p_ext;
        @(posedge mclk) disable iff (!rst_n)
        ##1 external_supply_indicator == $past(ext_supply_present);
    endproperty
    a_ext: assert property (p_ext) else $error("supply lamp wrong");

    property p_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (normal_now && !cat_any) |=> (!link_err_led && run_led);
    endproperty
    a_quiet: assert property (p_quiet) else $error("link error lamp lit");

endmodule

/* File: verification/bsli_net_model.sv */
// far side model: baton, send preparation beats and received frames
`timescale 1ns/1ns
module bsli_net_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] tok_gap,     // baton spacing, 0 stops it
    input  wire logic [7:0] prep_gap,    // preparation spacing, 0 stops it
    input  wire logic       frame_go,    // starts one frame
    input  wire logic [7:0] frame_len,   // bits in the frame, at least 1
    input  wire logic [7:0] frame_ones,  // leading ones of the frame
    output logic            token_rx,
    output logic            tx_prep_done,
    output logic            rx_bit_valid,
    output logic            rx_bit,
    output logic            rx_frame_end,
    output logic            rx_active
);
    logic [7:0] tok_cnt;   // cycles since last baton
    logic [7:0] prep_cnt;  // cycles since last preparation
    logic [7:0] bit_cnt;   // bit position in frame
    logic       idle_tgl;  // data line is not held outside frames
    assign rx_bit_valid = rx_active;
    assign rx_bit       = rx_active ? (bit_cnt < frame_ones) : idle_tgl;
    assign rx_frame_end = rx_active && (bit_cnt == frame_len - 8'h01);
    // periodic beats and frame sequencing
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tok_cnt      <= 8'h00;
            prep_cnt     <= 8'h00;
            token_rx     <= 1'b0;
            tx_prep_done <= 1'b0;
            bit_cnt      <= 8'h00;
            rx_active    <= 1'b0;
            idle_tgl     <= 1'b0;
        end
        else
        begin
            tok_cnt      <= (tok_cnt >= tok_gap) ? 8'h00 : tok_cnt + 8'h01;
            prep_cnt     <= (prep_cnt >= prep_gap) ? 8'h00 : prep_cnt + 8'h01;
            token_rx     <= (tok_gap != 8'h00) && (tok_cnt >= tok_gap);
            tx_prep_done <= (prep_gap != 8'h00) && (prep_cnt >= prep_gap);
            idle_tgl     <= ~idle_tgl;
            bit_cnt      <= (frame_go && !rx_active) ? 8'h00 : bit_cnt + 8'h01;
            if (frame_go && !rx_active)
                rx_active <= 1'b1;
            else if (rx_frame_end)
                rx_active <= 1'b0;
        end
    end
endmodule

/* File: verification/test_board_status_led_indicator.sv */
// self-checking bench of the board status indicator block
`timescale 1ns/1ns
`include "bsli_params.svh"
module test_board_status_led_indicator;
    localparam int FC = 4;  // short flash half period
    logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, c;
    logic [3:0] avs_byteenable;
    logic board_wdt_fail, driver_started, os_start_fail, driver_wdt_expire, pci_fault;
    logic crc_err, rx_item_arrive, rx_item_taken, rx_bit_valid, rx_bit, rx_frame_end;
    logic token_rx, bad_code, tx_prep_done, fwd_loop_fault, rev_loop_fault;
    logic tx_active, rx_active, ext_supply_present, run_led, link_err_led;
    logic transmit_activity_indicator, rx_activity_led, external_supply_indicator;
    logic abnormal_frame_flag, frame_go;
    logic [7:0] tok_gap, prep_gap, frame_len, frame_ones;
    int fails, checked, i, k, n, len, ones;
    bsli_top #(.FLASH_CYC(FC)) uut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq,
        .board_wdt_fail, .driver_started, .os_start_fail, .driver_wdt_expire, .pci_fault,
        .crc_err, .rx_item_arrive, .rx_item_taken, .rx_bit_valid, .rx_bit, .rx_frame_end,
        .token_rx, .bad_code, .tx_prep_done, .fwd_loop_fault, .rev_loop_fault, .tx_active,
        .rx_active, .ext_supply_present, .run_led, .link_err_led,
        .transmit_activity_indicator, .rx_activity_led, .external_supply_indicator,
        .abnormal_frame_flag);
    bsli_net_model net (.mclk, .rst_n, .tok_gap, .prep_gap, .frame_go, .frame_len,
        .frame_ones, .token_rx, .tx_prep_done, .rx_bit_valid, .rx_bit, .rx_frame_end,
        .rx_active);
    // free running clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic cyc(input int m);
        repeat (m) @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        @(posedge mclk);
        // the watchdog alone ends a wait that never answers
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // drives one event source
    task automatic ev(input int s, input logic v);
        case (s)
            0: crc_err <= v;
            1: rx_item_arrive <= v;
            2: bad_code <= v;
            3: fwd_loop_fault <= v;
            default: rev_loop_fault <= v;
        endcase
    endtask
    function automatic logic [31:0] sbit(input int s);
        case (s)
            0: return 32'h1 << `BSLI_ST_CRC;
            1: return 32'h1 << `BSLI_ST_OVER;
            2: return 32'h1 << `BSLI_ST_DATA;
            default: return 32'h1 << `BSLI_ST_LOOP;
        endcase
    endfunction
    function automatic logic abf_exp(input int l, input int o, input int lim, input int mn);
        return (o >= lim) || (l < mn);
    endfunction
    // watchdog against a hung run
    initial
    begin
        #(100 * 30000);
        fails++;
        complete_run();
    end
    initial
    begin
        {avs_read, avs_write, board_wdt_fail, driver_started, os_start_fail} = '0;
        {driver_wdt_expire, pci_fault, crc_err, rx_item_arrive, rx_item_taken} = '0;
        {bad_code, fwd_loop_fault, rev_loop_fault, tx_active, ext_supply_present} = '0;
        {avs_address, avs_writedata, frame_go, frame_len, frame_ones} = '0;
        avs_byteenable = 4'hf;
        tok_gap = 8'h14;
        prep_gap = 8'h14;
        rst_n = 1'b0;
        fails = 0;
        checked = 0;
        n = $urandom(32'h0bc99a6a);
        cyc(8);
        rst_n <= 1'b1;
        cyc(2);
        // reset values, unmapped place, held board
        bus(0, `BSLI_OFS_CHAN, 0); chk("chan", `BSLI_RST_CHAN, rd);
        bus(0, `BSLI_OFS_ONES_LIM, 0); chk("ones_lim", `BSLI_RST_ONES_LIM, rd);
        bus(0, `BSLI_OFS_MIN_LEN, 0); chk("min_len", `BSLI_RST_MIN_LEN, rd);
        bus(0, `BSLI_OFS_TOK_LIM, 0); chk("tok_lim", `BSLI_RST_TOK_LIM, rd);
        bus(0, `BSLI_OFS_UND_LIM, 0); chk("und_lim", `BSLI_RST_UND_LIM, rd);
        bus(0, 8'h24, 0); chk("unmapped", 32'h0, rd);
        chk("run held", 1'b0, run_led);
        $display("test reset done");
        driver_started <= 1'b1;
        cyc(3);
        chk("run", 1'b1, run_led);
        chk("err idle", 1'b0, link_err_led);
        board_wdt_fail <= 1'b1;
        cyc(3);
        chk("run wdt", 1'b0, run_led);
        board_wdt_fail <= 1'b0;
        $display("test run done");
        // crc, overrun, bad code and both loop fault sources each light the lamp, are readable and clear
        bus(1, `BSLI_OFS_MASK, 32'h7f);
        for (k = 0; k < 5; k++)
        begin
            bus(0, `BSLI_OFS_STATUS, 0);
            ev(k, 1'b1);
            cyc(k == 1 ? 2 : 1);
            ev(k, 1'b0);
            rx_item_taken <= (k == 1);
            cyc(3);
            rx_item_taken <= 1'b0;
            chk("err lamp", 1'b1, link_err_led);
            chk("irq", 1'b1, irq);
            bus(0, `BSLI_OFS_STATUS, 0); chk("status", sbit(k), rd);
            bus(0, `BSLI_OFS_STATUS, 0); chk("cleared", 32'h0, rd);
            chk("err off", 1'b0, link_err_led);
        end
        // arrival taken in the same cycle is no overrun; masked event
        bus(1, `BSLI_OFS_MASK, 32'h0);
        rx_item_arrive <= 1'b1;
        crc_err <= 1'b1;
        cyc(1);
        rx_item_taken <= 1'b1;
        crc_err <= 1'b0;
        cyc(1);
        rx_item_arrive <= 1'b0;
        cyc(1);
        rx_item_taken <= 1'b0;
        cyc(2);
        chk("irq masked", 1'b0, irq);
        bus(0, `BSLI_OFS_STATUS, 0); chk("no overrun", sbit(0), rd);
        $display("test events done");
        // missing baton and late preparation
        for (k = 0; k < 2; k++)
        begin
            bus(1, k ? `BSLI_OFS_UND_LIM : `BSLI_OFS_TOK_LIM, 32'd30);
            if (k) prep_gap <= 8'h00; else tok_gap <= 8'h00;
            cyc(40);
            tok_gap <= 8'h0a;
            prep_gap <= 8'h0a;
            cyc(15);
            bus(0, `BSLI_OFS_STATUS, 0);
            chk("timeout", 32'h1 << (k ? `BSLI_ST_UNDER : `BSLI_ST_TIME), rd);
            cyc(60);
            bus(0, `BSLI_OFS_STATUS, 0); chk("prompt", 32'h0, rd);
        end
        $display("test timeout done");
        // frames: corners first, then random
        bus(1, `BSLI_OFS_ONES_LIM, 32'd4);
        bus(1, `BSLI_OFS_MIN_LEN, 32'd8);
        for (i = 0; i < 12; i++)
        begin
            len = (i == 0) ? 10 : (i == 1) ? 8 : (i == 2) ? 7 : 1 + $urandom % 20;
            ones = (i == 0) ? 3 : (i == 1) ? 4 : (i == 2) ? 0 : $urandom % (len + 1);
            frame_len <= len[7:0];
            frame_ones <= ones[7:0];
            frame_go <= 1'b1;
            cyc(1);
            frame_go <= 1'b0;
            cyc(2);
            chk("rx lamp", 1'b1, rx_activity_led);
            cyc(len + 2);
            chk("abf", abf_exp(len, ones, 4, 8), abnormal_frame_flag);
            bus(0, `BSLI_OFS_STATUS, 0);
            chk("abf status", abf_exp(len, ones, 4, 8) << `BSLI_ST_ABF, rd);
        end
        $display("test frames done");
        // random activity, supply and held board
        for (i = 0; i < 8; i++)
        begin
            c = $urandom;
            tx_active <= c[0];
            ext_supply_present <= c[1];
            driver_started <= c[2] | (i == 0);
            cyc(3);
            chk("send lamp", c[0], transmit_activity_indicator);
            chk("supply", c[1], external_supply_indicator);
            chk("run", c[2] | (i == 0), run_led);
        end
        driver_started <= 1'b1;
        tx_active <= 1'b0;
        // board faults flash run and name the fault
        for (k = 0; k < 3; k++)
        begin
            {os_start_fail, driver_wdt_expire, pci_fault} <= 3'b100 >> k;
            cyc(3);
            c = {link_err_led, transmit_activity_indicator, rx_activity_led};
            chk("fault lamps", 3'b100 >> k, c);
            n = 0;
            for (i = 0; i < 24; i++)
            begin
                c[0] = run_led;
                @(posedge mclk);
                n += (run_led !== c[0]);
            end
            chk("flashing", 1'b1, n >= 24 / FC - 1);
        end
        {os_start_fail, driver_wdt_expire, pci_fault} <= 3'b000;
        $display("test faults done");
        // channel view shows channel number
        for (k = 0; k < 4; k++)
        begin
            c = $urandom;
            bus(1, `BSLI_OFS_CHAN, c);
            bus(1, `BSLI_OFS_CTRL, 32'h1);
            cyc(2);
            chk("chan view", c[3:0], {run_led, link_err_led,
                transmit_activity_indicator, rx_activity_led});
            bus(0, `BSLI_OFS_CHAN, 0); chk("chan reg", {24'h0, c[7:0]}, rd);
            bus(1, `BSLI_OFS_CTRL, 32'h0);
            cyc(2);
            chk("run back", 1'b1, run_led);
        end
        $display("test channel done");
        complete_run();
    end
endmodule
